// >>> rtl/cwp_pkg.sv
package cwp_pkg;
    // clock and power-up delay figures
    localparam int CLK_KHZ = 20000;
    localparam int PUT_SHORT_MS = 1;
    localparam int PUT_MID_MS = 16;
    localparam int PUT_LONG_MS = 64;
    localparam int PUT_SHORT_CYC = PUT_SHORT_MS * CLK_KHZ;
    localparam int PUT_MID_CYC = PUT_MID_MS * CLK_KHZ;
    localparam int PUT_LONG_CYC = PUT_LONG_MS * CLK_KHZ;
    localparam int PUT_CNT_W = 21;

    // register word addresses
    localparam logic [15:0] ADR_REV = 16'h8005;
    localparam logic [15:0] ADR_PART = 16'h8006;
    localparam logic [15:0] ADR_CFG2 = 16'h8008;
    localparam logic [15:0] ADR_CFG3 = 16'h8009;
    localparam logic [15:0] ADR_CFG4 = 16'h800A;
    localparam logic [15:0] ADR_CFG5 = 16'h800B;
    localparam logic [15:0] ADR_STAT = 16'h8010;

    // field positions of the configuration and status words
    localparam int B_MASTER_CLEAR_PIN_ENABLE = 0;
    localparam int B_PUTS = 1;
    localparam int B_LVP = 13;
    localparam int B_WSAF = 11;
    localparam int B_WCFG = 9;
    localparam int B_WBOOT = 8;
    localparam int B_WAPP = 7;
    localparam int B_STORAGE_AREA_ENABLE_N = 4;
    localparam int B_BOOT_REGION_ENABLE_N = 3;
    localparam int B_BBSZ = 0;
    localparam int B_CP = 0;
    localparam int B_ST_REFUSED = 0;
    localparam int B_ST_LVP = 1;

    // power-up delay selection codes
    localparam logic [1:0] PUTS_1MS = 2'h0;
    localparam logic [1:0] PUTS_16MS = 2'h1;
    localparam logic [1:0] PUTS_64MS = 2'h2;
    localparam logic [1:0] PUTS_OFF = 2'h3;

    // word values and masks
    localparam logic [13:0] WORD_ERASED = 14'h3FFF;
    localparam logic [13:0] PROT_MASK4 = 14'h0B80;
    localparam logic [1:0] REV_RSVD = 2'h2;
    localparam logic [1:0] PART_RSVD = 2'h3;

    // program counter vectors and boot block ends
    localparam logic [14:0] RESET_VEC = 15'h0000;
    localparam logic [14:0] IRQ_VEC = 15'h0004;
    localparam int SAF_WORDS = 128;
    localparam logic [14:0] BB_END_7 = 15'h01FF;
    localparam logic [14:0] BB_END_6 = 15'h03FF;
    localparam logic [14:0] BB_END_5 = 15'h07FF;
    localparam logic [14:0] BB_END_4 = 15'h0FFF;
    localparam logic [14:0] BB_END_3 = 15'h1FFF;
    localparam logic [14:0] BB_END_LOW = 15'h3FFF;

    typedef enum logic [0:0] {
        PU_WAIT = 1'b0,
        PU_DONE = 1'b1
    } cwp_pu_t;
endpackage : cwp_pkg

// >>> rtl/cwp_config_decode.sv
// What this block does
// - power-up delay select 01 gives 16 ms, 00 gives 1 ms.
// - power-up delay select 11 disables the timer, 10 gives 64 ms.
// - reset pin is reset when low-voltage mode on, else enable bit decides.
// - bit 13 set enables low-voltage programming and overrides pin enable bit.
// - clearing low-voltage enable is refused while that path is programming.
// - bit 11 low locks storage area, only when storage area enabled.
// - bit 9 low blocks all configuration word writes.
// - bit 8 low locks boot block, only when boot block enabled.
// - bit 7 low locks application block of program flash.
// - protection bits return to unprotected only through bulk erase.
// - boot block enabled when bit 3 is 0.
// - three-bit size code selects boot block end address.
// - boot size changes only while boot block disabled, else bulk erase.
// - boot block never exceeds half of implemented program memory.
// - code protection on when bit 0 of word five is 0.
// - code protection acts at once, cleared only by bulk erase.
// - part word shows part code, bits 13 and 12 read 1.
// - revision word shows major and minor revision, bits 13:12 read 10.
// - fifteen-bit program counter wraps inside implemented memory.
// - execution starts at 0000h after reset, interrupts go to 0004h.
// - implemented memory is 2048 or 4096 words by variant.
`timescale 1ns/1ns
`default_nettype none
module cwp_config_decode #(
    parameter int PFM_WORDS = 2048,           // 2048 or 4096
    parameter logic [11:0] PART_CODE = 12'h5A5, // arbitrary value
    parameter logic [5:0] MAJOR_REV = 6'h01,  // arbitrary value
    parameter logic [5:0] MINOR_REV = 6'h00,  // arbitrary value
    parameter int PUT_SHORT_CYC = cwp_pkg::PUT_SHORT_CYC,
    parameter int PUT_MID_CYC = cwp_pkg::PUT_MID_CYC,
    parameter int PUT_LONG_CYC = cwp_pkg::PUT_LONG_CYC
) (
    input wire logic clk_i,                   // 20 MHz clock
    input wire logic reset_i,                 // sync reset, high
    input wire logic [15:0] addr_i,           // register address
    input wire logic [13:0] wdata_i,          // write data
    input wire logic wr_i,                    // write strobe
    input wire logic rd_i,                    // read strobe
    output logic [13:0] rdata_o,              // read data, next cycle
    input wire logic [13:0] nv_cfg2_i,        // stored word 2
    input wire logic [13:0] nv_cfg4_i,        // stored word 4
    input wire logic [13:0] nv_cfg5_i,        // stored word 5
    input wire logic bulk_erase_i,            // bulk erase pulse
    input wire logic lvp_active_i,            // low-voltage path in use
    input wire logic pc_step_i,               // advance program counter
    input wire logic pc_jump_i,               // load program counter
    input wire logic [14:0] pc_target_i,      // jump target
    input wire logic irq_take_i,              // take interrupt vector
    output logic [14:0] pc_o,                 // program counter
    input wire logic [14:0] chk_addr_i,       // self-write address to check
    output logic chk_locked_o,                // that address is locked
    output logic master_clear_pin_is_reset_o,             // reset pin acts as reset
    output logic lvp_enable_o,                // low-voltage programming on
    output logic cfg_locked_o,                // config words locked
    output logic boot_locked_o,               // boot block locked
    output logic app_locked_o,                // application block locked
    output logic saf_locked_o,                // storage area locked
    output logic boot_enable_o,               // boot block partition on
    output logic saf_enable_o,                // storage area on
    output logic [14:0] boot_end_o,           // last boot block address
    output logic code_protect_o,              // code protection on
    output logic power_up_done_o              // power-up delay elapsed
);
    localparam logic [14:0] ADDR_MASK = 15'(PFM_WORDS - 1);
    localparam logic [14:0] HALF_END = 15'(PFM_WORDS / 2 - 1);
    localparam logic [14:0] SAF_START = 15'(PFM_WORDS - cwp_pkg::SAF_WORDS);

    typedef struct packed {
        logic [13:0] cfg2;
        logic [13:0] cfg4;
        logic [13:0] cfg5;
        logic [13:0] act2;
        logic [13:0] act4;
        cwp_pkg::cwp_pu_t pu;
        logic [cwp_pkg::PUT_CNT_W-1:0] pu_cnt;
        logic refused;
        logic [14:0] pc;
        logic [13:0] rdata;
        logic chk_locked;
        logic master_clear_pin_is_reset;
        logic lvp_enable;
        logic cfg_locked;
        logic boot_locked;
        logic app_locked;
        logic saf_locked;
        logic boot_enable;
        logic saf_enable;
        logic [14:0] boot_end;
        logic code_protect;
    } cwp_st_t;

    cwp_st_t q;
    cwp_st_t d;

    // boot block end from size code, capped at half the memory
    function automatic logic [14:0] boot_end_of(input logic [2:0] code);
        logic [14:0] e;
        unique case (code)
            3'h7: e = cwp_pkg::BB_END_7;
            3'h6: e = cwp_pkg::BB_END_6;
            3'h5: e = cwp_pkg::BB_END_5;
            3'h4: e = cwp_pkg::BB_END_4;
            3'h3: e = cwp_pkg::BB_END_3;
            default: e = cwp_pkg::BB_END_LOW;
        endcase
        if (e > HALF_END) begin
            e = HALF_END;
        end
        return e;
    endfunction : boot_end_of

    // power-up delay length for a selection code
    function automatic logic [cwp_pkg::PUT_CNT_W-1:0] put_len(input logic [1:0] sel);
        logic [cwp_pkg::PUT_CNT_W-1:0] n;
        unique case (sel)
            cwp_pkg::PUTS_1MS: n = cwp_pkg::PUT_CNT_W'(PUT_SHORT_CYC);
            cwp_pkg::PUTS_16MS: n = cwp_pkg::PUT_CNT_W'(PUT_MID_CYC);
            cwp_pkg::PUTS_64MS: n = cwp_pkg::PUT_CNT_W'(PUT_LONG_CYC);
            default: n = '0;
        endcase
        return n;
    endfunction : put_len

    // decoded views of the live image and the latched copy
    logic lvp_act;
    logic boot_en_act;
    logic saf_en_act;
    logic [14:0] bend_act;
    logic wlock_cfg;
    logic [1:0] puts;
    logic [cwp_pkg::PUT_CNT_W-1:0] pu_len;
    logic [14:0] chk_a;

    assign lvp_act = q.act4[cwp_pkg::B_LVP];
    assign boot_en_act = ~q.act4[cwp_pkg::B_BOOT_REGION_ENABLE_N];
    assign saf_en_act = ~q.act4[cwp_pkg::B_STORAGE_AREA_ENABLE_N];
    assign bend_act = boot_end_of(q.act4[cwp_pkg::B_BBSZ +: 3]);
    // lock uses the live image so a fresh lock bites at once
    assign wlock_cfg = ~q.cfg4[cwp_pkg::B_WCFG];
    assign puts = q.act2[cwp_pkg::B_PUTS +: 2];
    assign pu_len = put_len(puts);
    assign chk_a = chk_addr_i & ADDR_MASK;

    // next state: reset load, bulk erase, register writes, timers
    always_comb begin
        logic [13:0] nw;
        logic refuse_ev;
        logic refuse_clr;
        nw = '0;
        refuse_ev = 1'b0;
        refuse_clr = 1'b0;
        d = q;

        // register writes; protection bits only move toward protected
        if (wr_i) begin
            unique case (addr_i)
                cwp_pkg::ADR_CFG2: begin
                    if (wlock_cfg) begin
                        refuse_ev = 1'b1;
                    end else begin
                        d.cfg2 = wdata_i;
                    end
                end
                cwp_pkg::ADR_CFG4: begin
                    if (wlock_cfg) begin
                        refuse_ev = 1'b1;
                    end else begin
                        nw = wdata_i;
                        nw = nw & (~cwp_pkg::PROT_MASK4 | q.cfg4);
                        if (!q.cfg4[cwp_pkg::B_BOOT_REGION_ENABLE_N]) begin
                            nw[cwp_pkg::B_BBSZ +: 3] = q.cfg4[cwp_pkg::B_BBSZ +: 3];
                        end
                        if (lvp_active_i && !wdata_i[cwp_pkg::B_LVP]) begin
                            nw[cwp_pkg::B_LVP] = q.cfg4[cwp_pkg::B_LVP];
                        end
                        refuse_ev = (nw != wdata_i);
                        d.cfg4 = nw;
                    end
                end
                cwp_pkg::ADR_CFG5: begin
                    if (wlock_cfg) begin
                        refuse_ev = 1'b1;
                    end else begin
                        nw = wdata_i;
                        nw[cwp_pkg::B_CP] = wdata_i[cwp_pkg::B_CP] & q.cfg5[cwp_pkg::B_CP];
                        refuse_ev = (nw != wdata_i);
                        d.cfg5 = nw;
                    end
                end
                cwp_pkg::ADR_STAT: begin
                    refuse_clr = wdata_i[cwp_pkg::B_ST_REFUSED];
                end
                default: begin
                    refuse_ev = 1'b0; // read-only or unmapped: ignored
                end
            endcase
        end
        // a refusal in the clearing cycle still sticks
        d.refused = (q.refused & ~refuse_clr) | refuse_ev;

        // read data stand for one cycle only
        d.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                cwp_pkg::ADR_REV: d.rdata = {cwp_pkg::REV_RSVD, MAJOR_REV, MINOR_REV};
                cwp_pkg::ADR_PART: d.rdata = {cwp_pkg::PART_RSVD, PART_CODE};
                cwp_pkg::ADR_CFG2: d.rdata = q.cfg2;
                cwp_pkg::ADR_CFG4: d.rdata = q.cfg4;
                cwp_pkg::ADR_CFG5: d.rdata = q.cfg5;
                cwp_pkg::ADR_STAT: begin
                    d.rdata[cwp_pkg::B_ST_REFUSED] = q.refused;
                    d.rdata[cwp_pkg::B_ST_LVP] = lvp_active_i;
                end
                default: d.rdata = '0; // reserved word and unmapped
            endcase
        end

        // bulk erase returns every word to the unprotected state
        if (bulk_erase_i) begin
            d.cfg2 = cwp_pkg::WORD_ERASED;
            d.cfg4 = cwp_pkg::WORD_ERASED;
            d.cfg5 = cwp_pkg::WORD_ERASED;
            d.act2 = cwp_pkg::WORD_ERASED;
            d.act4 = cwp_pkg::WORD_ERASED;
        end

        // power-up timer runs once after reset release
        unique case (q.pu)
            cwp_pkg::PU_WAIT: begin
                d.pu_cnt = q.pu_cnt + 1'b1;
                if (puts == cwp_pkg::PUTS_OFF || q.pu_cnt + 1'b1 >= pu_len) begin
                    d.pu = cwp_pkg::PU_DONE;
                end
            end
            cwp_pkg::PU_DONE: begin
                d.pu_cnt = q.pu_cnt;
            end
        endcase

        // program counter: interrupt over jump over step, all wrapped
        if (irq_take_i) begin
            d.pc = cwp_pkg::IRQ_VEC;
        end else if (pc_jump_i) begin
            d.pc = pc_target_i & ADDR_MASK;
        end else if (pc_step_i) begin
            d.pc = (q.pc + 15'h0001) & ADDR_MASK;
        end

        // registered decoded outputs
        d.master_clear_pin_is_reset = lvp_act | q.act2[cwp_pkg::B_MASTER_CLEAR_PIN_ENABLE];
        d.lvp_enable = lvp_act;
        d.cfg_locked = wlock_cfg;
        d.boot_locked = ~q.cfg4[cwp_pkg::B_WBOOT] & boot_en_act;
        d.app_locked = ~q.cfg4[cwp_pkg::B_WAPP];
        d.saf_locked = ~q.cfg4[cwp_pkg::B_WSAF] & saf_en_act;
        d.boot_enable = boot_en_act;
        d.saf_enable = saf_en_act;
        d.boot_end = boot_en_act ? bend_act : 15'h0000;
        d.code_protect = ~q.cfg5[cwp_pkg::B_CP];
        // self-write check: storage area, then boot block, then application
        if (saf_en_act && chk_a >= SAF_START) begin
            d.chk_locked = ~q.cfg4[cwp_pkg::B_WSAF];
        end else if (boot_en_act && chk_a <= bend_act) begin
            d.chk_locked = ~q.cfg4[cwp_pkg::B_WBOOT];
        end else begin
            d.chk_locked = ~q.cfg4[cwp_pkg::B_WAPP];
        end

        // reset latches the stored words and restarts everything
        if (reset_i) begin
            d = '0;
            d.cfg2 = nv_cfg2_i;
            d.cfg4 = nv_cfg4_i;
            d.cfg5 = nv_cfg5_i;
            d.act2 = nv_cfg2_i;
            d.act4 = nv_cfg4_i;
            d.pu = cwp_pkg::PU_WAIT;
            d.pc = cwp_pkg::RESET_VEC;
        end
    end

    // single state register
    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // outputs straight from flip-flops
    assign rdata_o = q.rdata;
    assign pc_o = q.pc;
    assign chk_locked_o = q.chk_locked;
    assign master_clear_pin_is_reset_o = q.master_clear_pin_is_reset;
    assign lvp_enable_o = q.lvp_enable;
    assign cfg_locked_o = q.cfg_locked;
    assign boot_locked_o = q.boot_locked;
    assign app_locked_o = q.app_locked;
    assign saf_locked_o = q.saf_locked;
    assign boot_enable_o = q.boot_enable;
    assign saf_enable_o = q.saf_enable;
    assign boot_end_o = q.boot_end;
    assign code_protect_o = q.code_protect;
    assign power_up_done_o = (q.pu == cwp_pkg::PU_DONE);
endmodule : cwp_config_decode
`default_nettype wire

// >>> sim/cwp_config_decode_properties.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_config_decode_properties #(
    parameter int PFM_WORDS = 2048
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic [13:0] rdata_o,
    input wire logic bulk_erase_i,
    input wire logic pc_step_i,
    input wire logic pc_jump_i,
    input wire logic irq_take_i,
    input wire logic [14:0] pc_o,
    input wire logic master_clear_pin_is_reset_o,
    input wire logic lvp_enable_o,
    input wire logic cfg_locked_o,
    input wire logic boot_locked_o,
    input wire logic app_locked_o,
    input wire logic saf_locked_o,
    input wire logic boot_enable_o,
    input wire logic saf_enable_o,
    input wire logic [14:0] boot_end_o,
    input wire logic code_protect_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // reads of the identity words, answered the cycle after the strobe
    sequence s_rd_part;
        rd_i && addr_i == cwp_pkg::ADR_PART;
    endsequence
    sequence s_rd_rev;
        rd_i && addr_i == cwp_pkg::ADR_REV;
    endsequence
    sequence s_step;
        pc_step_i && !pc_jump_i && !irq_take_i;
    endsequence
    // erase reloads the words, the decode follows a cycle later
    sequence s_erase;
        bulk_erase_i ##1 1'b1;
    endsequence
    // two cycles clear of reset and erase, so the latched copy cannot move
    sequence s_settled;
        !$past(reset_i) && !$past(reset_i, 2) && !$past(bulk_erase_i) && !$past(bulk_erase_i, 2);
    endsequence
    a_part_rsvd: assert property (s_rd_part |=> rdata_o[13:12] == cwp_pkg::PART_RSVD)
        else $error("part word reserved bits wrong");
    a_rev_rsvd: assert property (s_rd_rev |=> rdata_o[13:12] == cwp_pkg::REV_RSVD)
        else $error("revision word reserved bits wrong");
    a_pc_wrap: assert property (s_step |=> pc_o == (($past(pc_o) + 15'h0001) & 15'(PFM_WORDS - 1)))
        else $error("program counter step or wrap wrong");
    a_irq_vector: assert property (irq_take_i |=> pc_o == cwp_pkg::IRQ_VEC)
        else $error("interrupt vector wrong");
    a_erase_unlock: assert property (s_erase |=> !app_locked_o && !cfg_locked_o
        && !boot_locked_o && !saf_locked_o && !code_protect_o)
        else $error("lock survived bulk erase");
    a_cfg_frozen: assert property (s_settled |-> $stable({boot_enable_o, boot_end_o, lvp_enable_o}))
        else $error("latched decode changed without reset or erase");
    a_master_clear_pin_lvp: assert property (lvp_enable_o |-> master_clear_pin_is_reset_o)
        else $error("reset pin not reset while low-voltage mode on");
    a_boot_half: assert property (boot_end_o <= 15'(PFM_WORDS / 2 - 1))
        else $error("boot block above half of memory");
    a_boot_off: assert property (!boot_enable_o |-> boot_end_o == 15'h0000 && !boot_locked_o)
        else $error("boot block decode while disabled");
    a_saf_off: assert property (!saf_enable_o |-> !saf_locked_o)
        else $error("storage area locked while disabled");
endmodule : cwp_config_decode_properties
bind cwp_config_decode cwp_config_decode_properties #(.PFM_WORDS(PFM_WORDS)) u_props (.clk_i, .reset_i, .addr_i,
    .rd_i, .rdata_o, .bulk_erase_i, .pc_step_i, .pc_jump_i, .irq_take_i, .pc_o, .master_clear_pin_is_reset_o, .lvp_enable_o,
    .cfg_locked_o, .boot_locked_o, .app_locked_o, .saf_locked_o, .boot_enable_o, .saf_enable_o, .boot_end_o,
    .code_protect_o);
`default_nettype wire

// >>> sim/cwp_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_prog_model (
    input wire logic clk_i,        // system clock
    input wire logic load_i,       // new image request
    input wire logic [13:0] w2_i,  // word 2 to store
    input wire logic [13:0] w4_i,  // word 4 to store
    input wire logic [13:0] w5_i,  // word 5 to store
    output logic [13:0] nv2_o,     // stored word 2
    output logic [13:0] nv4_o,     // stored word 4
    output logic [13:0] nv5_o      // stored word 5
);
    logic cp_due_q;
    // code protect word goes in last, since it locks the part at once
    always @(posedge clk_i) begin
        cp_due_q <= load_i;
        if (load_i) begin
            nv2_o <= w2_i | 14'h2000;
            nv4_o <= w4_i;
        end
        if (cp_due_q) nv5_o <= w5_i;
    end
endmodule : cwp_prog_model
`default_nettype wire

// >>> sim/cwp_config_decode_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_config_decode_tb;
    localparam logic [5:0] MJ = 6'h05; // arbitrary value
    localparam logic [5:0] MN = 6'h2A; // arbitrary value
    localparam logic [11:0] PID = 12'h3C1; // arbitrary value
    localparam int PUT_N[4] = '{5, 10, 20, 1};
    logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, bulk_erase_i = 1'b0, lvp_active_i = 1'b0;
    logic pc_step_i = 1'b0, pc_jump_i = 1'b0, irq_take_i = 1'b0, ld = 1'b0, rd_seen = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [13:0] wdata_i = 14'h0000, rdata_o, nv2, nv4, nv5, w2 = 14'h3FFF, w4 = 14'h3FFF, w5 = 14'h3FFF;
    logic [14:0] pc_target_i = 15'h0000, chk_addr_i = 15'h0000, pc_o, boot_end_o;
    logic chk_locked_o, master_clear_pin_is_reset_o, lvp_enable_o, cfg_locked_o, boot_locked_o, app_locked_o;
    logic saf_locked_o, boot_enable_o, saf_enable_o, code_protect_o, power_up_done_o;
    logic [13:0] exp_q[$];
    int err_count = 0, comparisons = 0, k;
    cwp_config_decode #(.PFM_WORDS(2048), .PART_CODE(PID), .MAJOR_REV(MJ), .MINOR_REV(MN),
        .PUT_SHORT_CYC(5), .PUT_MID_CYC(10), .PUT_LONG_CYC(20)) uut (.clk_i, .reset_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .nv_cfg2_i(nv2), .nv_cfg4_i(nv4), .nv_cfg5_i(nv5), .bulk_erase_i,
        .lvp_active_i, .pc_step_i, .pc_jump_i, .pc_target_i, .irq_take_i, .pc_o, .chk_addr_i, .chk_locked_o,
        .master_clear_pin_is_reset_o, .lvp_enable_o, .cfg_locked_o, .boot_locked_o, .app_locked_o, .saf_locked_o,
        .boot_enable_o, .saf_enable_o, .boot_end_o, .code_protect_o, .power_up_done_o);
    cwp_prog_model u_prog (.clk_i, .load_i(ld), .w2_i(w2), .w4_i(w4), .w5_i(w5), .nv2_o(nv2), .nv4_o(nv4),
        .nv5_o(nv5));
    // 50 ns clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // strobes stay up between calls, so back-to-back cycles never drive a signal twice
    task automatic wr(input logic [15:0] a, input logic [13:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [13:0] e);
        addr_i <= a;
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
    endtask : rd
    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        bulk_erase_i <= 1'b0;
        pc_step_i <= 1'b0;
        pc_jump_i <= 1'b0;
        irq_take_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : idle
    task automatic pcx(input logic s, input logic j, input logic q, input logic [14:0] t);
        pc_step_i <= s;
        pc_jump_i <= j;
        irq_take_i <= q;
        pc_target_i <= t;
        @(posedge clk_i);
    endtask : pcx
    // programmer loads the words while reset is held for 12 cycles
    task automatic boot(input logic [13:0] a, input logic [13:0] b, input logic [13:0] c);
        reset_i <= 1'b1;
        w2 <= a;
        w4 <= b;
        w5 <= c;
        ld <= 1'b1;
        @(posedge clk_i);
        ld <= 1'b0;
        repeat (11) @(posedge clk_i);
        reset_i <= 1'b0;
    endtask : boot
    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // read answers land one cycle after the strobe; match them in issue order
    always @(posedge clk_i) begin
        if (rd_seen) check({1'b0, rdata_o}, {1'b0, exp_q.pop_front()});
        rd_seen <= rd_i;
    end
    // hang guard, far beyond the length of the sequence
    initial begin
        repeat (4000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        k = $urandom(28347);
        // every power-up code, reset pin role and boot size code
        for (int i = 0; i < 8; i++) begin
            boot({11'h7FF, i[1:0], i[2]}, {i[0], 9'h1FF, 1'b0, i[2:0]}, 14'h3FFF);
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (power_up_done_o !== 1'b1 && k < 40);
            check(15'(k), 15'(PUT_N[i % 4] + 1));
            check(15'(master_clear_pin_is_reset_o), 15'(i[0] | i[2]));
            check({13'h0000, lvp_enable_o, boot_enable_o}, {13'h0000, i[0], 1'b1});
            check(boot_end_o, (i == 7) ? 15'h01FF : 15'h03FF);
        end
        boot(14'h3FFF, 14'h3FFF, 14'h3FFF);
        @(posedge clk_i);
        check(pc_o, 15'h0000);
        rd(cwp_pkg::ADR_REV, {2'h2, MJ, MN});
        wr(cwp_pkg::ADR_PART, 14'h0000);
        rd(cwp_pkg::ADR_PART, {2'h3, PID});
        rd(cwp_pkg::ADR_CFG3, 14'h0000);
        rd(16'h8100, 14'h0000);
        // lock, then try to unlock without an erase
        wr(cwp_pkg::ADR_CFG4, 14'h3F7F);
        wr(cwp_pkg::ADR_CFG4, 14'h3FFF);
        rd(cwp_pkg::ADR_STAT, 14'h0001);
        wr(cwp_pkg::ADR_CFG5, 14'h3FFE);
        wr(cwp_pkg::ADR_CFG5, 14'h3FFF);
        wr(cwp_pkg::ADR_STAT, 14'h0001);
        wr(cwp_pkg::ADR_CFG4, 14'h357F);
        wr(cwp_pkg::ADR_CFG4, 14'h347F);
        rd(cwp_pkg::ADR_STAT, 14'h0001);
        for (int i = 0; i < 4; i++) begin
            chk_addr_i <= 15'($urandom);
            idle(2);
            check(15'(chk_locked_o), 15'h0001);
        end
        check({11'h000, app_locked_o, cfg_locked_o, saf_locked_o, code_protect_o}, 15'h000D);
        bulk_erase_i <= 1'b1;
        @(posedge clk_i);
        idle(3);
        check({11'h000, app_locked_o, cfg_locked_o, saf_locked_o, code_protect_o}, 15'h0000);
        // clearing low-voltage mode refused only while that path is in use
        lvp_active_i <= 1'b1;
        wr(cwp_pkg::ADR_STAT, 14'h0001);
        wr(cwp_pkg::ADR_CFG4, 14'h1FFF);
        rd(cwp_pkg::ADR_STAT, 14'h0003);
        lvp_active_i <= 1'b0;
        wr(cwp_pkg::ADR_STAT, 14'h0001);
        wr(cwp_pkg::ADR_CFG4, 14'h1FFF);
        rd(cwp_pkg::ADR_STAT, 14'h0000);
        wr(cwp_pkg::ADR_CFG4, 14'h1FF6);
        wr(cwp_pkg::ADR_CFG4, 14'h1FF5);
        rd(cwp_pkg::ADR_STAT, 14'h0001);
        idle(1);
        pcx(1'b0, 1'b1, 1'b0, 15'h07FF);
        pcx(1'b1, 1'b0, 1'b0, 15'h0000);
        idle(1);
        check(pc_o, 15'h0000);
        pcx(1'b1, 1'b0, 1'b1, 15'h0000);
        idle(1);
        check(pc_o, 15'h0004);
        for (int i = 0; i < 4; i++) begin
            pcx(1'b0, 1'b1, 1'b0, 15'($urandom));
            idle(1);
            check(pc_o, pc_target_i & 15'h07FF);
        end
        // both partitions on and locked: storage area, boot block, then application
        boot(14'h3FFF, 14'h36E7, 14'h3FFF);
        for (int i = 0; i < 3; i++) begin
            chk_addr_i <= (i == 0) ? 15'h7FF0 : ((i == 1) ? 15'h0100 : 15'h0400);
            idle(2);
            check(15'(chk_locked_o), 15'(i < 2));
        end
        check({11'h000, saf_enable_o, saf_locked_o, boot_enable_o, boot_locked_o}, 15'h000F);
        check(boot_end_o, 15'h01FF);
        tally_and_finish();
    end
endmodule : cwp_config_decode_tb
`default_nettype wire
